// file: rtl/dgp_pkg.sv
// package: register map, field positions, reset values and carrier types
// What this block does
// - pull-up on only for input with pull-ups allowed
// - pins 0-2 are I/O or external interrupt
// - pin 3 is I/O, interrupt three, or capture two
// - pins 4-7 I/O with change detect, pull-up
// - pins 5-7 serve serial programming when enabled
// - capture two on port three pin one when select=1
// - direction 1 floats pin, 0 drives latch
// - latch register reads back the latch, not pins
// - peripherals may force port three direction
// - override never written into direction register
// - reset leaves port three all inputs
// - port three pins 0-2 timer and capture functions
// - port three pins 3-5 serial port functions
// - port three pins 6-7 usart lines
// - change compare against snapshot from last port read or write sets flag
// - output pins excluded from change compare
package dgp_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_P2_PINS = 4'h0;
   localparam logic [3:0] OFS_P2_LAT = 4'h1;
   localparam logic [3:0] OFS_P2_DIR = 4'h2;
   localparam logic [3:0] OFS_IC_MAIN = 4'h3;
   localparam logic [3:0] OFS_IC_EDGE = 4'h4;
   localparam logic [3:0] OFS_IC_EXT = 4'h5;
   localparam logic [3:0] OFS_P3_PINS = 4'h6;
   localparam logic [3:0] OFS_P3_LAT = 4'h7;
   localparam logic [3:0] OFS_P3_DIR = 4'h8;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h9;
   localparam logic [3:0] OFS_IRQ_MASK = 4'hA;
   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int BIT_PULLUP_DIS = 7;
   localparam int BIT_CHANGE_IE = 3;
   localparam int BIT_CHANGE_FLAG = 0;
   localparam int BIT_EXT0_FLAG = 1;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_IC_MAIN = 8'h00;
   localparam logic [7:0] RST_IC_EDGE = 8'hFF;
   localparam logic [7:0] RST_IC_EXT = 8'hC0;
   localparam logic [7:0] RST_LAT = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   // port two pins idle high, so edge and change logic starts quiet after reset
   localparam logic [7:0] RST_PIN_IDLE = 8'hFF;
   // status bits: 0 port change, 1..4 external interrupt 0..3 edge seen
   localparam int STAT_CHANGE = 0;
   localparam int STAT_EXT0 = 1;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dgp_req_t;

   typedef struct packed {
      logic [7:0] p2_lat_r;
      logic [7:0] p2_dir_r;
      logic [7:0] p3_lat_r;
      logic [7:0] p3_dir_r;
      logic [7:0] ic_main_r;
      logic [7:0] ic_edge_r;
      logic [7:0] ic_ext_r;
      logic [7:0] stat_r;
      logic [7:0] mask_r;
      logic [3:0] snap_r;
      logic [7:0] p2_s1_r;
      logic [7:0] p2_s2_r;
      logic [7:0] p2_s3_r;
      logic [7:0] p3_s1_r;
      logic [7:0] p3_s2_r;
      logic [7:0] p3_s3_r;
      logic [7:0] p2_pin_r;
      logic [7:0] p3_pin_r;
      logic [7:0] rdata_r;
   } dgp_state_t;
endpackage

// file: rtl/dgp_port.sv
// module: two general purpose ports, port two with pull-ups and change detect, both with overrides
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module dgp_port (
   input wire logic clk, // 40 MHz core clock
   input wire logic srst, // synchronous reset, active high
   input wire dgp_pkg::dgp_req_t req, // register request
   output logic [7:0] rdata, // read data, cycle after read strobe
   input wire logic [7:0] p2_in, // port two pin levels
   output logic [7:0] p2_out, // port two driven levels
   output logic [7:0] p2_oe_n, // port two output enable, low drives
   output logic [7:0] p2_pullup_en, // port two weak pull-up enables
   input wire logic [7:0] p3_in, // port three pin levels
   output logic [7:0] p3_out, // port three driven levels
   output logic [7:0] p3_oe_n, // port three output enable, low drives
   input wire logic [7:0] p3_force_out, // peripheral forces pin to output
   input wire logic [7:0] p3_force_in, // peripheral forces pin to input
   input wire logic [7:0] p3_periph_out, // peripheral data for forced pins
   input wire logic capture_two_pin_select, // config: 1 puts capture two on p3 pin 1
   input wire logic capture_two_out, // capture two output level
   input wire logic capture_two_oe, // capture two drives its pin
   output logic capture_two_in, // capture two input from selected pin
   input wire logic low_voltage_prog_enable, // serial programming mode active
   output logic [3:0] ext_irq_in, // external interrupt pin levels 0..3
   output logic [3:0] serial_prog_pins, // pins 4..7 seen by programming logic
   output logic irq // level interrupt
);
   dgp_pkg::dgp_state_t s;
   dgp_pkg::dgp_state_t n;
   logic [7:0] p2_dir_eff;
   logic [7:0] p3_dir_eff;
   logic [3:0] mism;
   logic p2_read;

   // ----------------------------------------------------------------
   // pin direction and data
   // ----------------------------------------------------------------
   always_comb begin
      p2_dir_eff = s.p2_dir_r;
      // capture two driving its alternate pin when not selected on port three
      if (!capture_two_pin_select && capture_two_oe) begin
         p2_dir_eff[3] = 1'b0;
      end
      // programming mode takes pins 5..7 away from I/O
      if (low_voltage_prog_enable) begin
         p2_dir_eff[7:5] = 3'b111;
      end
      // overrides act on the pin only; the register keeps software value
      p3_dir_eff = (s.p3_dir_r & ~p3_force_out) | p3_force_in;
      if (capture_two_pin_select && capture_two_oe) begin
         p3_dir_eff[1] = 1'b0;
      end
   end

   always_comb begin
      p2_out = s.p2_lat_r;
      if (!capture_two_pin_select && capture_two_oe) begin
         p2_out[3] = capture_two_out;
      end
      p3_out = (s.p3_lat_r & ~p3_force_out) | (p3_periph_out & p3_force_out);
      if (capture_two_pin_select && capture_two_oe) begin
         p3_out[1] = capture_two_out;
      end
      p2_oe_n = p2_dir_eff;
      p3_oe_n = p3_dir_eff;
      // pull-ups only on inputs while not globally disabled
      p2_pullup_en = p2_dir_eff & {8{~s.ic_edge_r[dgp_pkg::BIT_PULLUP_DIS]}};
      if (low_voltage_prog_enable) begin
         p2_pullup_en[5] = 1'b0;
      end
      capture_two_in = capture_two_pin_select ? s.p3_pin_r[1] : s.p2_pin_r[3];
      ext_irq_in = s.p2_pin_r[3:0];
      serial_prog_pins = s.p2_pin_r[7:4];
      rdata = s.rdata_r;
      irq = |(s.stat_r & s.mask_r);
   end

   // ----------------------------------------------------------------
   // change detect and next state
   // ----------------------------------------------------------------
   // one place decides whether a strobe hits a given register
   function automatic logic hit(input dgp_pkg::dgp_req_t r, input logic [3:0] ofs,
         input logic is_wr);
      hit = (is_wr ? r.wr : r.rd) && (r.addr == ofs);
   endfunction

   assign p2_read = hit(req, dgp_pkg::OFS_P2_PINS, 1'b0);
   // outputs never mismatch
   assign mism = (s.p2_pin_r[7:4] ^ s.snap_r) & p2_dir_eff[7:4];

   always_comb begin
      n = s;
      // three-stage pin synchronisers; change counts when stages 2 and 3 agree
      n.p2_s1_r = p2_in;
      n.p2_s2_r = s.p2_s1_r;
      n.p2_s3_r = s.p2_s2_r;
      n.p3_s1_r = p3_in;
      n.p3_s2_r = s.p3_s1_r;
      n.p3_s3_r = s.p3_s2_r;
      for (int i = 0; i < 8; i++) begin
         if (s.p2_s2_r[i] == s.p2_s3_r[i]) begin
            n.p2_pin_r[i] = s.p2_s3_r[i];
         end
         if (s.p3_s2_r[i] == s.p3_s3_r[i]) begin
            n.p3_pin_r[i] = s.p3_s3_r[i];
         end
      end
      n.rdata_r = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            dgp_pkg::OFS_P2_PINS: n.rdata_r = s.p2_pin_r;
            dgp_pkg::OFS_P2_LAT: n.rdata_r = s.p2_lat_r;
            dgp_pkg::OFS_P2_DIR: n.rdata_r = s.p2_dir_r;
            dgp_pkg::OFS_IC_MAIN: n.rdata_r = s.ic_main_r;
            dgp_pkg::OFS_IC_EDGE: n.rdata_r = s.ic_edge_r;
            dgp_pkg::OFS_IC_EXT: n.rdata_r = s.ic_ext_r;
            dgp_pkg::OFS_P3_PINS: n.rdata_r = s.p3_pin_r;
            dgp_pkg::OFS_P3_LAT: n.rdata_r = s.p3_lat_r;
            dgp_pkg::OFS_P3_DIR: n.rdata_r = s.p3_dir_r;
            dgp_pkg::OFS_IRQ_STAT: n.rdata_r = s.stat_r;
            dgp_pkg::OFS_IRQ_MASK: n.rdata_r = s.mask_r;
            default: n.rdata_r = 8'h00;
         endcase
      end
      // a read or write of the port ends the mismatch
      if (p2_read || hit(req, dgp_pkg::OFS_P2_PINS, 1'b1)) begin
         n.snap_r = s.p2_pin_r[7:4];
      end
      if (hit(req, dgp_pkg::OFS_IRQ_STAT, 1'b0)) begin
         n.stat_r = 8'h00;
      end
      if (req.wr) begin
         unique case (req.addr)
            dgp_pkg::OFS_P2_PINS: n.p2_lat_r = req.wdata;
            dgp_pkg::OFS_P2_LAT: n.p2_lat_r = req.wdata;
            dgp_pkg::OFS_P2_DIR: n.p2_dir_r = req.wdata;
            dgp_pkg::OFS_IC_MAIN: n.ic_main_r = req.wdata;
            dgp_pkg::OFS_IC_EDGE: n.ic_edge_r = req.wdata;
            dgp_pkg::OFS_IC_EXT: n.ic_ext_r = req.wdata;
            dgp_pkg::OFS_P3_PINS: n.p3_lat_r = req.wdata;
            dgp_pkg::OFS_P3_LAT: n.p3_lat_r = req.wdata;
            dgp_pkg::OFS_P3_DIR: n.p3_dir_r = req.wdata;
            dgp_pkg::OFS_IRQ_MASK: n.mask_r = req.wdata;
            default: n.mask_r = s.mask_r;
         endcase
      end
      // sustained mismatch keeps setting the flag; set beats software clear
      if (|mism) begin
         n.ic_main_r[dgp_pkg::BIT_CHANGE_FLAG] = 1'b1;
         n.stat_r[dgp_pkg::STAT_CHANGE] = 1'b1;
      end
      // rising edge on an input pin 0..3 marks the external event
      for (int i = 0; i < 4; i++) begin
         if (n.p2_pin_r[i] && !s.p2_pin_r[i] && p2_dir_eff[i]) begin
            n.stat_r[dgp_pkg::STAT_EXT0 + i] = 1'b1;
         end
      end
      if (srst) begin
         n.p2_lat_r = dgp_pkg::RST_LAT;
         n.p3_lat_r = dgp_pkg::RST_LAT;
         n.p2_dir_r = dgp_pkg::RST_DIR;
         n.p3_dir_r = dgp_pkg::RST_DIR;
         n.ic_main_r = dgp_pkg::RST_IC_MAIN;
         n.ic_edge_r = dgp_pkg::RST_IC_EDGE;
         n.ic_ext_r = dgp_pkg::RST_IC_EXT;
         n.stat_r = 8'h00;
         n.mask_r = dgp_pkg::RST_MASK;
         n.snap_r = dgp_pkg::RST_PIN_IDLE[7:4];
         n.p2_s1_r = dgp_pkg::RST_PIN_IDLE;
         n.p2_s2_r = dgp_pkg::RST_PIN_IDLE;
         n.p2_s3_r = dgp_pkg::RST_PIN_IDLE;
         n.p3_s1_r = 8'h00;
         n.p3_s2_r = 8'h00;
         n.p3_s3_r = 8'h00;
         n.p2_pin_r = dgp_pkg::RST_PIN_IDLE;
         n.p3_pin_r = 8'h00;
         n.rdata_r = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      s <= n;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   pullup_gate_a: assert property (@(posedge clk) disable iff (srst)
      p2_pullup_en[0] |-> (p2_oe_n[0] && !s.ic_edge_r[dgp_pkg::BIT_PULLUP_DIS]))
      else $error("pull-up on while pin drives or disabled");
   p3_drive_a: assert property (@(posedge clk) disable iff (srst)
      (!s.p3_dir_r[2] && !p3_force_in[2] && !p3_force_out[2]) |-> (!p3_oe_n[2] && p3_out[2] == s.p3_lat_r[2]))
      else $error("port three pin not driving latch");
   force_dir_a: assert property (@(posedge clk) disable iff (srst)
      p3_force_out[5] && !p3_force_in[5] |-> !p3_oe_n[5])
      else $error("forced output not driven");
   dir_keep_a: assert property (@(posedge clk) disable iff (srst)
      (p3_force_out != 8'h00 && !(req.wr && req.addr == dgp_pkg::OFS_P3_DIR)) |=> s.p3_dir_r == $past(s.p3_dir_r))
      else $error("override leaked into direction register");
   reset_dir_a: assert property (@(posedge clk) srst |=> (s.p3_dir_r == 8'hFF && s.p2_dir_r == 8'hFF))
      else $error("direction not all inputs after reset");
   lat_read_a: assert property (@(posedge clk) disable iff (srst)
      (req.rd && req.addr == dgp_pkg::OFS_P3_LAT) |=> rdata == $past(s.p3_lat_r))
      else $error("latch read not latch value");
   change_flag_a: assert property (@(posedge clk) disable iff (srst)
      (|mism) |=> s.ic_main_r[dgp_pkg::BIT_CHANGE_FLAG] && irq == s.mask_r[0])
      else $error("mismatch did not set change flag");
   out_excl_a: assert property (@(posedge clk) disable iff (srst)
      (p2_dir_eff[7:4] == 4'h0) |-> mism == 4'h0)
      else $error("output pin joined change compare");
   cap_sel_a: assert property (@(posedge clk) disable iff (srst)
      capture_two_pin_select |-> capture_two_in == s.p3_pin_r[1])
      else $error("capture two on wrong pin");

   // ----------------------------------------------------------------
   // register access checks
   // ----------------------------------------------------------------
   sequence p2_pins_read_s;
      hit(req, dgp_pkg::OFS_P2_PINS, 1'b0);
   endsequence

   sequence p3_dir_read_s;
      hit(req, dgp_pkg::OFS_P3_DIR, 1'b0);
   endsequence

   sequence stat_read_s;
      hit(req, dgp_pkg::OFS_IRQ_STAT, 1'b0);
   endsequence

   pin_read_a: assert property (@(posedge clk) disable iff (srst)
      p2_pins_read_s |=> rdata == $past(s.p2_pin_r))
      else $error("port two read not pin levels");

   snap_take_a: assert property (@(posedge clk) disable iff (srst)
      p2_pins_read_s |=> s.snap_r == $past(s.p2_pin_r[7:4]))
      else $error("read did not capture change snapshot");

   dir_read_a: assert property (@(posedge clk) disable iff (srst)
      p3_dir_read_s |=> rdata == $past(s.p3_dir_r))
      else $error("direction read not software value");

   stat_read_a: assert property (@(posedge clk) disable iff (srst)
      stat_read_s |=> rdata == $past(s.stat_r))
      else $error("status read wrong");

   p3_pin_read_a: assert property (@(posedge clk) disable iff (srst)
      hit(req, dgp_pkg::OFS_P3_PINS, 1'b0) |=> rdata == $past(s.p3_pin_r))
      else $error("port three read not pin levels");

   p2_lat_read_a: assert property (@(posedge clk) disable iff (srst)
      hit(req, dgp_pkg::OFS_P2_LAT, 1'b0) |=> rdata == $past(s.p2_lat_r))
      else $error("port two latch read wrong");

   port_write_a: assert property (@(posedge clk) disable iff (srst)
      hit(req, dgp_pkg::OFS_P2_PINS, 1'b1) |=> s.p2_lat_r == $past(req.wdata))
      else $error("port write missed latch");

   lat_write_a: assert property (@(posedge clk) disable iff (srst)
      hit(req, dgp_pkg::OFS_P3_LAT, 1'b1) |=> s.p3_lat_r == $past(req.wdata))
      else $error("latch write lost");

   rdata_idle_a: assert property (@(posedge clk) disable iff (srst)
      !req.rd |=> rdata == 8'h00)
      else $error("read data stands too long");

   // ----------------------------------------------------------------
   // pull-up and programming checks
   // ----------------------------------------------------------------
   pull_out_a: assert property (@(posedge clk) disable iff (srst)
      (p2_pullup_en & ~p2_oe_n) == 8'h00)
      else $error("pull-up on a driven pin");

   pull_dis_a: assert property (@(posedge clk) disable iff (srst)
      s.ic_edge_r[dgp_pkg::BIT_PULLUP_DIS] |-> p2_pullup_en == 8'h00)
      else $error("pull-up on while disabled");

   pull_on_a: assert property (@(posedge clk) disable iff (srst)
      (!s.ic_edge_r[dgp_pkg::BIT_PULLUP_DIS] && !low_voltage_prog_enable)
      |-> p2_pullup_en == p2_oe_n)
      else $error("input pin lacks pull-up");

   pull_rst_a: assert property (@(posedge clk) srst |=> p2_pullup_en == 8'h00)
      else $error("pull-ups on after reset");

   prog_pull_a: assert property (@(posedge clk) disable iff (srst)
      low_voltage_prog_enable |-> !p2_pullup_en[5])
      else $error("pull-up on programming enable pin");

   prog_dir_a: assert property (@(posedge clk) disable iff (srst)
      low_voltage_prog_enable |-> p2_oe_n[7:5] == 3'b111)
      else $error("programming pins driven");

   prog_pins_a: assert property (@(posedge clk) disable iff (srst)
      serial_prog_pins == s.p2_pin_r[7:4])
      else $error("programming pins not synced levels");

   // ----------------------------------------------------------------
   // pin function checks
   // ----------------------------------------------------------------
   ext_level_a: assert property (@(posedge clk) disable iff (srst)
      ext_irq_in == s.p2_pin_r[3:0])
      else $error("interrupt inputs not synced levels");

   ext_flag_a: assert property (@(posedge clk) disable iff (srst)
      (n.p2_pin_r[0] && !s.p2_pin_r[0] && p2_dir_eff[0]) |=> s.stat_r[dgp_pkg::STAT_EXT0])
      else $error("external edge not flagged");

   p2_drive_a: assert property (@(posedge clk) disable iff (srst)
      !s.p2_dir_r[4] |-> (!p2_oe_n[4] && p2_out[4] == s.p2_lat_r[4]))
      else $error("port two pin not driving latch");

   cap_alt_a: assert property (@(posedge clk) disable iff (srst)
      (!capture_two_pin_select && capture_two_oe)
      |-> (!p2_oe_n[3] && p2_out[3] == capture_two_out))
      else $error("capture two missing on alternate pin");

   cap_home_a: assert property (@(posedge clk) disable iff (srst)
      (capture_two_pin_select && capture_two_oe)
      |-> (!p3_oe_n[1] && p3_out[1] == capture_two_out))
      else $error("capture two missing on port three");

   cap_in_alt_a: assert property (@(posedge clk) disable iff (srst)
      !capture_two_pin_select |-> capture_two_in == s.p2_pin_r[3])
      else $error("capture two input on wrong pin");

   cap_quiet_a: assert property (@(posedge clk) disable iff (srst)
      (!capture_two_oe && !p3_force_out[1]) |-> p3_out[1] == s.p3_lat_r[1])
      else $error("idle capture two took the pin");

   force_in_a: assert property (@(posedge clk) disable iff (srst)
      p3_force_in[0] |-> p3_oe_n[0])
      else $error("forced input still driven");

   timer_pin_a: assert property (@(posedge clk) disable iff (srst)
      (p3_force_out[2] && !p3_force_in[2]) |-> p3_out[2] == p3_periph_out[2])
      else $error("peripheral data missing on pin two");

   serial_pin_a: assert property (@(posedge clk) disable iff (srst)
      (p3_force_out[5] && !p3_force_in[5]) |-> p3_out[5] == p3_periph_out[5])
      else $error("peripheral data missing on pin five");

   usart_pin_a: assert property (@(posedge clk) disable iff (srst)
      (p3_force_out[6] && !p3_force_in[6]) |-> (!p3_oe_n[6] && p3_out[6] == p3_periph_out[6]))
      else $error("peripheral data missing on pin six");

   p3_float_a: assert property (@(posedge clk) disable iff (srst)
      (s.p3_dir_r[7] && !p3_force_out[7]) |-> p3_oe_n[7])
      else $error("input pin driven");
endmodule // dgp_port

// file: sim/dgp_pins.sv
// pin model: outside drivers, weak pull-ups and floating lines of one port
`timescale 1ns/1ps
module dgp_pins (
   input wire logic clk, // core clock
   input wire logic [7:0] out, // levels the block drives
   input wire logic [7:0] oe_n, // low where the block drives
   input wire logic [7:0] pull, // weak pull-up enables
   input wire logic [7:0] ext, // levels the outside drives
   input wire logic [7:0] ext_en, // outside drives these pins
   output logic [7:0] pin // resolved pin level
);
   // a released line with no pull-up toggles every clock, so the synchroniser never agrees and keeps its last stable level
   logic [7:0] flt_r = 8'h55;
   always_ff @(posedge clk) begin
      flt_r <= ~flt_r;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!oe_n[i]) pin[i] = out[i];
         else if (ext_en[i]) pin[i] = ext[i];
         else if (pull[i]) pin[i] = 1'b1;
         else pin[i] = flt_r[i];
      end
   end
endmodule // dgp_pins

// file: sim/dual_gpio_port_pullup_override_test.sv
// testbench: register walk, pin drive, overrides, pull-ups, change detect, irq
`timescale 1ns/1ps
module dual_gpio_port_pullup_override_test;
   typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e;} dgp_row_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   dgp_pkg::dgp_req_t req = '0;
   logic [7:0] rdata, p2_out, p2_oe_n, p2_pu, p3_out, p3_oe_n, p2_pin, p3_pin, tmp;
   logic [7:0] p2_ext = 8'hFF, p2_ee = 8'hFF, p3_ext = 8'h3C;
   logic [7:0] f_out = 8'h00, f_in = 8'h00, p_out = 8'h00;
   logic sel = 1'b1, c2_out = 1'b1, c2_oe = 1'b0, lvp = 1'b0, c2_in, irq;
   logic [3:0] ext_irq, prog_pins;
   int errors = 0, total_checks = 0;
   dgp_row_t rows [13] = '{'{1'b0, 4'h8, 8'h00, 8'hFF}, '{1'b0, 4'h2, 8'h00, 8'hFF},
      '{1'b0, 4'h3, 8'h00, 8'h00}, '{1'b0, 4'h4, 8'h00, 8'hFF}, '{1'b0, 4'h5, 8'h00, 8'hC0},
      '{1'b0, 4'hA, 8'h00, 8'h00}, '{1'b1, 4'h8, 8'h5A, 8'h5A}, '{1'b1, 4'h7, 8'hC3, 8'hC3},
      '{1'b1, 4'h1, 8'h3C, 8'h3C}, '{1'b1, 4'h2, 8'h0F, 8'h0F}, '{1'b1, 4'h4, 8'h7F, 8'h7F},
      '{1'b1, 4'hA, 8'h01, 8'h01}, '{1'b1, 4'hB, 8'h55, 8'h00}};
   always #12.5 clk = ~clk;
   dgp_port u_dut (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .p2_in(p2_pin),
      .p2_out(p2_out), .p2_oe_n(p2_oe_n), .p2_pullup_en(p2_pu), .p3_in(p3_pin),
      .p3_out(p3_out), .p3_oe_n(p3_oe_n), .p3_force_out(f_out), .p3_force_in(f_in),
      .p3_periph_out(p_out), .capture_two_pin_select(sel), .capture_two_out(c2_out),
      .capture_two_oe(c2_oe), .capture_two_in(c2_in), .low_voltage_prog_enable(lvp),
      .ext_irq_in(ext_irq), .serial_prog_pins(prog_pins), .irq(irq));
   dgp_pins u_p2 (.clk(clk), .out(p2_out), .oe_n(p2_oe_n), .pull(p2_pu), .ext(p2_ext),
      .ext_en(p2_ee), .pin(p2_pin));
   dgp_pins u_p3 (.clk(clk), .out(p3_out), .oe_n(p3_oe_n), .pull(8'h00), .ext(p3_ext),
      .ext_en(8'hFF), .pin(p3_pin));
   // ----------------------------------------------------------------
   // bus cycles and comparison
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t ns: got %h, want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      rd(a, tmp);
      chk(tmp, e);
   endtask
   task automatic settle;
      repeat (6) @(negedge clk);
   endtask
   task automatic give_verdict;
      $display("checks %0d, errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk(p3_oe_n, 8'hFF);
      chk(p2_pu, 8'h00);
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rc(rows[i].a, rows[i].e);
      end
      chk(p3_oe_n, 8'h5A);
      chk(p3_out & ~p3_oe_n, 8'h81);
      rc(4'h6, 8'h99);
      wr(4'h0, 8'h66);
      rc(4'h1, 8'h66);
      @(posedge clk);
      f_out <= 8'h02;
      f_in <= 8'h80;
      @(negedge clk);
      chk(p3_oe_n, 8'hD8);
      chk(p3_out & 8'h02, 8'h00);
      rc(4'h8, 8'h5A);
      chk(p2_pu, 8'h0F);
      @(posedge clk);
      f_out <= 8'h00;
      f_in <= 8'h00;
      p2_ee <= 8'hF0;
      settle();
      rc(4'h0, 8'h6F);
      wr(4'h4, 8'hFF);
      p2_ee <= 8'hFF;
      @(negedge clk);
      chk(p2_pu, 8'h00);
      wr(4'h2, 8'h00);
      lvp <= 1'b1;
      @(negedge clk);
      chk(p2_oe_n, 8'hE0);
      wr(4'h2, 8'hFF);
      wr(4'h4, 8'h7F);
      @(negedge clk);
      chk(p2_pu, 8'hDF);
      @(posedge clk);
      lvp <= 1'b0;
      p2_ext <= 8'hF5;
      p3_ext <= 8'h3E;
      settle();
      chk({4'h0, ext_irq}, 8'h05);
      chk({4'h0, prog_pins}, 8'h0F);
      chk({7'h00, c2_in}, 8'h01);
      @(posedge clk);
      sel <= 1'b0;
      c2_oe <= 1'b1;
      settle();
      chk({7'h00, c2_in}, 8'h01);
      chk(p2_oe_n, 8'hF7);
      @(posedge clk);
      c2_oe <= 1'b0;
      settle();
      rd(4'h0, tmp);
      wr(4'h3, 8'h00);
      rd(4'h9, tmp);
      rc(4'h3, 8'h00);
      @(posedge clk);
      p2_ext <= 8'hE5;
      settle();
      rc(4'h3, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr(4'hA, 8'h00);
      @(negedge clk);
      chk({7'h00, irq}, 8'h00);
      wr(4'hA, 8'h01);
      rd(4'h0, tmp);
      rd(4'h9, tmp);
      chk(tmp & 8'h01, 8'h01);
      rd(4'h9, tmp);
      chk(tmp & 8'h01, 8'h00);
      wr(4'h3, 8'h00);
      wr(4'h2, 8'hEF);
      rd(4'h0, tmp);
      wr(4'h1, 8'h76);
      settle();
      rc(4'h3, 8'h00);
      chk({7'h00, irq}, 8'h00);
      give_verdict();
   end
endmodule // dual_gpio_port_pullup_override_test
